// ---- design/dma_byte_count_and_packing.v ----
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dma_cnt_defs.vh"
module dma_byte_count_and_packing (
  input wire core_clk,
  input wire sys_rst,
  input wire [1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire rd_req,
  output wire [1:0] rd_size,
  output wire single_cycle,
  input wire rd_ack,
  input wire rd_err,
  input wire [31:0] rd_data,
  output wire wr_req,
  output wire [1:0] wr_size,
  output wire [31:0] wr_data,
  input wire wr_ack,
  input wire wr_err,
  input wire dreq_pin,
  output wire done_hs
);

  // Engine states.
  localparam ST_IDLE = 3'd0;
  localparam ST_CHECK = 3'd1;
  localparam ST_ARM = 3'd2;
  localparam ST_READ = 3'd3;
  localparam ST_LOAD = 3'd4;
  localparam ST_WRITE = 3'd5;

  // Slave port registers.
  reg avs_wait_q;
  reg [31:0] avs_rdata_q;
  // Control register fields.
  reg channel_go_bit_q;
  reg [1:0] src_size_q;
  reg [1:0] dst_size_q;
  reg single_q;
  reg ext_q;
  // Sticky status flags: setup, destination error, source error, done.
  reg [3:0] channel_status_register_q;
  // Bytes still to move.
  reg [31:0] remaining_byte_count_q;
  // Engine state and byte pointers into the holding buffer.
  reg [2:0] state_q;
  reg [2:0] rd_ptr_q;
  reg [2:0] wr_ptr_q;
  // Outgoing bus cycle requests and the handshake pulse.
  reg rd_req_q;
  reg [1:0] rd_size_q;
  reg single_cycle_q;
  reg wr_req_q;
  reg [1:0] wr_size_q;
  reg [31:0] wr_data_q;
  reg done_hs_q;
  // Two-stage synchroniser for the external request pin.
  reg dreq_meta_q;
  reg dreq_sync_q;

  assign avs_readdata = avs_rdata_q;
  assign avs_waitrequest = avs_wait_q;
  assign rd_req = rd_req_q;
  assign rd_size = rd_size_q;
  assign single_cycle = single_cycle_q;
  assign wr_req = wr_req_q;
  assign wr_size = wr_size_q;
  assign wr_data = wr_data_q;
  assign done_hs = done_hs_q;

  // Operand widths in bytes, and the group width that packing works on.
  wire [2:0] src_bytes = 3'd1 << src_size_q;
  wire [2:0] dst_bytes = 3'd1 << dst_size_q;
  wire [2:0] unit_bytes = (single_q || src_bytes > dst_bytes) ? src_bytes : dst_bytes;
  // Summary of all sticky flags; while it is set a new start is refused.
  wire status_pending = |channel_status_register_q;

  // A bus access is answered in the cycle when waitrequest is low.
  wire bus_wr = avs_write && !avs_wait_q;

  // Count check against the operand size, done when go is first seen.
  wire cfg_bad = (remaining_byte_count_q == 32'h0000_0000) ||
    (src_size_q == 2'h3) || (dst_size_q == 2'h3) ||
    ((unit_bytes == 3'd2) && remaining_byte_count_q[0]) ||
    ((unit_bytes == 3'd4) && (remaining_byte_count_q[1:0] != 2'h0));

  // Completion of the outgoing bus cycles.
  wire rd_fin = (state_q == ST_READ) && rd_req_q && (rd_ack || rd_err);
  wire wr_fin = (state_q == ST_WRITE) && wr_req_q && (wr_ack || wr_err);
  wire rd_ok = rd_fin && !rd_err;
  wire wr_ok = wr_fin && !wr_err;

  // The count drops on a good write, or on a good single-address cycle.
  wire dec_en = wr_ok || (rd_ok && single_q);
  wire [2:0] dec_bytes = single_q ? src_bytes : dst_bytes;
  wire [31:0] cnt_next = remaining_byte_count_q - {29'h0, dec_bytes};

  // Hardware events that set status flags.
  wire ev_done = dec_en && (cnt_next == 32'h0000_0000);
  wire ev_srcerr = rd_fin && rd_err;
  wire ev_dsterr = wr_fin && wr_err;
  wire ev_setup = (state_q == ST_CHECK) && cfg_bad;
  wire [3:0] ev_vec = {ev_setup, ev_dsterr, ev_srcerr, ev_done};

  // Holding buffer tap for the next destination operand.
  wire [31:0] hold_take;

  // Read data goes into the hidden buffer only for dual-address transfers.
  operand_holding_buffer u_hold (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(rd_ok && !single_q),
    .load_ofs(rd_ptr_q[1:0]),
    .load_bytes(src_bytes),
    .load_data(rd_data),
    .take_ofs(wr_ptr_q[1:0]),
    .take_data(hold_take)
  );

  // The request pin is from outside the clock domain: two flops first.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dreq_meta_q <= 1'b0;
      dreq_sync_q <= 1'b0;
    end else begin
      dreq_meta_q <= dreq_pin;
      dreq_sync_q <= dreq_meta_q;
    end
  end

  // Slave handshake: waitrequest drops for one cycle per request.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_wait_q <= 1'b1;
      avs_rdata_q <= 32'h0000_0000;
    end else begin
      if ((avs_read || avs_write) && avs_wait_q) begin
        // Answer the request on the next edge.
        avs_wait_q <= 1'b0;
      end else begin
        // Idle, or the answer has just been taken.
        avs_wait_q <= 1'b1;
      end
      if (avs_read && avs_wait_q) begin
        // Read data is latched alongside the drop of waitrequest.
        if (avs_address == `REG_CTRL_IDX) begin
          avs_rdata_q <= {25'h0, ext_q, single_q, dst_size_q, src_size_q, channel_go_bit_q};
        end else if (avs_address == `REG_STAT_IDX) begin
          avs_rdata_q <= {24'h0, status_pending, 3'h0, channel_status_register_q};
        end else if (avs_address == `REG_COUNT_IDX) begin
          // The live count always names the next access.
          avs_rdata_q <= remaining_byte_count_q;
        end else begin
          // Unmapped word reads as zero.
          avs_rdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  // Control fields and the go bit.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_go_bit_q <= 1'b0;
      src_size_q <= `SIZE_BYTE;
      dst_size_q <= `SIZE_BYTE;
      single_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      if (|ev_vec) begin
        // Done, bus errors and setup errors all stop the channel.
        channel_go_bit_q <= 1'b0;
      end else if (bus_wr && (avs_address == `REG_CTRL_IDX) && avs_byteenable[0]) begin
        if (!avs_writedata[`CTRL_GO_BIT]) begin
          // Writing zero stops the channel.
          channel_go_bit_q <= 1'b0;
        end else if (!status_pending) begin
          // Start is refused while any status flag is still set.
          channel_go_bit_q <= 1'b1;
        end
      end
      if (bus_wr && (avs_address == `REG_CTRL_IDX) && avs_byteenable[0]) begin
        src_size_q <= avs_writedata[`CTRL_SRC_LSB +: 2];
        dst_size_q <= avs_writedata[`CTRL_DST_LSB +: 2];
        single_q <= avs_writedata[`CTRL_SINGLE_BIT];
        ext_q <= avs_writedata[`CTRL_EXTREQ_BIT];
      end
    end
  end

  // Status flags: hardware sets win over a write-one clear in the same cycle.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_status_register_q <= `STAT_RST;
    end else if (bus_wr && (avs_address == `REG_STAT_IDX) && avs_byteenable[0]) begin
      // Ones clear, zeros leave the flag alone.
      channel_status_register_q <= (channel_status_register_q & ~avs_writedata[3:0]) | ev_vec;
    end else begin
      // No register write: hardware events can only add flags.
      channel_status_register_q <= channel_status_register_q | ev_vec;
    end
  end

  // Remaining count: software writes take priority over a decrement.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      remaining_byte_count_q <= `COUNT_RST;
    end else if (bus_wr && (avs_address == `REG_COUNT_IDX)) begin
      // Byte enables select which lanes are replaced.
      if (avs_byteenable[0]) remaining_byte_count_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) remaining_byte_count_q[15:8] <= avs_writedata[15:8];
      if (avs_byteenable[2]) remaining_byte_count_q[23:16] <= avs_writedata[23:16];
      if (avs_byteenable[3]) remaining_byte_count_q[31:24] <= avs_writedata[31:24];
    end else if (dec_en) begin
      // A failed cycle leaves the count on the access to be retried.
      remaining_byte_count_q <= cnt_next;
    end
  end

  // Transfer engine: dual-address reads fill the buffer, writes drain it.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      rd_ptr_q <= 3'd0;
      wr_ptr_q <= 3'd0;
      rd_req_q <= 1'b0;
      rd_size_q <= `SIZE_BYTE;
      single_cycle_q <= 1'b0;
      wr_req_q <= 1'b0;
      wr_size_q <= `SIZE_BYTE;
      wr_data_q <= 32'h0000_0000;
      done_hs_q <= 1'b0;
    end else begin
      // Handshake toward the peripheral is a single-cycle pulse.
      done_hs_q <= ev_done && ext_q;
      rd_size_q <= src_size_q;
      wr_size_q <= dst_size_q;
      single_cycle_q <= single_q;
      case (state_q)
        ST_IDLE: begin
          // Wait for the go bit.
          if (channel_go_bit_q) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // A bad count ends here with no bus cycle at all.
          if (cfg_bad) begin
            state_q <= ST_IDLE;
          end else begin
            // Count and sizes agree: begin the first group.
            state_q <= ST_ARM;
          end
        end
        ST_ARM: begin
          // Start a new group; in external mode wait for the pin.
          rd_ptr_q <= 3'd0;
          wr_ptr_q <= 3'd0;
          if (!channel_go_bit_q) begin
            // Software stopped the channel; it halts at this group boundary.
            state_q <= ST_IDLE;
          end else if (!ext_q || dreq_sync_q) begin
            // Open the first source cycle of the group.
            rd_req_q <= 1'b1;
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          if (rd_fin) begin
            rd_req_q <= 1'b0;
            if (rd_err) begin
              // A source fault stops the channel with the count untouched.
              state_q <= ST_IDLE;
            end else if (single_q) begin
              // Single-address cycle moves the data directly.
              state_q <= ev_done ? ST_IDLE : ST_ARM;
            end else if (rd_ptr_q + src_bytes == unit_bytes) begin
              // Group is full: go write it out.
              rd_ptr_q <= rd_ptr_q + src_bytes;
              state_q <= ST_LOAD;
            end else begin
              // More source operands are needed to pack this group.
              rd_ptr_q <= rd_ptr_q + src_bytes;
            end
          end else if (!rd_req_q) begin
            // Reopen the source cycle for the next packed operand.
            rd_req_q <= 1'b1;
          end
        end
        ST_LOAD: begin
          // Take the next destination operand from the buffer.
          wr_data_q <= hold_take;
          wr_req_q <= 1'b1;
          state_q <= ST_WRITE;
        end
        ST_WRITE: begin
          if (wr_fin) begin
            wr_req_q <= 1'b0;
            if (wr_err || ev_done) begin
              // A destination fault or the final write ends the run.
              state_q <= ST_IDLE;
            end else if (wr_ptr_q + dst_bytes == unit_bytes) begin
              // Group drained: fetch the next one.
              state_q <= ST_ARM;
            end else begin
              // Unpacking: further destination operands remain.
              wr_ptr_q <= wr_ptr_q + dst_bytes;
              state_q <= ST_LOAD;
            end
          end
        end
        default: begin
          // Unused state codes fall back to idle.
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- design/dma_cnt_defs.vh ----
`ifndef DMA_CNT_DEFS_VH
`define DMA_CNT_DEFS_VH

// Register word indices on the slave port (byte address is four times these).
`define REG_CTRL_IDX 2'h0
`define REG_STAT_IDX 2'h1
`define REG_COUNT_IDX 2'h2

// Control register field positions.
`define CTRL_GO_BIT 0
`define CTRL_SRC_LSB 1
`define CTRL_DST_LSB 3
`define CTRL_SINGLE_BIT 5
`define CTRL_EXTREQ_BIT 6

// Status register field positions.
`define STAT_DONE_BIT 0
`define STAT_SRCERR_BIT 1
`define STAT_DSTERR_BIT 2
`define STAT_SETUP_BIT 3
`define STAT_PEND_BIT 7

// Operand size codes.
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

// Reset values.
`define CTRL_RST 7'h00
`define STAT_RST 4'h0
`define COUNT_RST 32'h0000_0000

`endif

// ---- design/operand_holding_buffer.v ----
`timescale 1ns/1ps
// Internal 32-bit holding buffer used to pack and unpack operands.
// It has no address on the register port; only the transfer engine sees it.
module operand_holding_buffer (
  input wire core_clk,
  input wire sys_rst,
  input wire load,
  input wire [1:0] load_ofs,
  input wire [2:0] load_bytes,
  input wire [31:0] load_data,
  input wire [1:0] take_ofs,
  output wire [31:0] take_data
);

  // Holding storage, gathered from one register per byte lane.
  wire [31:0] hold_all;
  // Incoming operand moved up to its byte offset.
  wire [31:0] placed;
  // Offset widened so the lane comparison cannot wrap.
  wire [2:0] ofs_w;

  assign placed = load_data << {load_ofs, 3'b000};
  assign ofs_w = {1'b0, load_ofs};
  // Outgoing operand shifted down so it sits in the low lanes.
  assign take_data = hold_all >> {take_ofs, 3'b000};

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      // One byte of storage; each lane has a register and a process of its own.
      reg [7:0] lane_q;
      assign hold_all[lane*8 +: 8] = lane_q;
      // Each lane loads only when the incoming operand covers it.
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          lane_q <= 8'h00;
        end else if (load && (lane >= ofs_w) && (lane < ofs_w + load_bytes)) begin
          lane_q <= placed[lane*8 +: 8];
        end
      end
    end
  endgenerate

endmodule

// ---- bench/dma_cnt_properties.sv ----
`timescale 1ns/1ps
// Watches the register port and both transfer handshakes of the counting block.
module dma_cnt_properties (
  input wire core_clk,
  input wire sys_rst,
  input wire [1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire rd_req,
  input wire [1:0] rd_size,
  input wire single_cycle,
  input wire rd_ack,
  input wire rd_err,
  input wire [31:0] rd_data,
  input wire wr_req,
  input wire [1:0] wr_size,
  input wire [31:0] wr_data,
  input wire wr_ack,
  input wire wr_err,
  input wire dreq_pin,
  input wire done_hs
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // A destination cycle that opens after an idle cycle.
  sequence s_wr_start;
    !wr_req ##1 wr_req;
  endsequence
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("register access not answered in one cycle");
  a_bus_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("register answer longer than one cycle");
  a_rd_hold: assert property (rd_req && !rd_ack && !rd_err |=> rd_req)
    else $error("source request dropped before its answer");
  a_wr_drop: assert property (wr_req && (wr_ack || wr_err) |=> !wr_req)
    else $error("destination request kept after its answer");
  a_wr_steady: assert property (wr_req && !wr_ack && !wr_err |=> $stable(wr_data))
    else $error("destination data changed while its cycle was open");
  a_one_cycle: assert property (!(rd_req && wr_req))
    else $error("source and destination cycles overlap");
  a_hs_pulse: assert property (done_hs |=> !done_hs)
    else $error("done handshake longer than one cycle");
  a_hs_cause: assert property (done_hs |-> $past(wr_ack) || $past(rd_ack))
    else $error("done handshake without a completed cycle");
  a_single_path: assert property (single_cycle |-> !wr_req)
    else $error("destination cycle in single-address mode");
  a_pack_write: assert property (s_wr_start ##0 (wr_size >= rd_size)
    |-> $past(rd_ack, 2)) else $error("packed write not two cycles after last read");
endmodule

// ---- bench/mem_partner.sv ----
`timescale 1ns/1ps
// Memory model: answers each cycle after lag cycles, or faults it on command.
module mem_partner (
  input wire core_clk,
  input wire sys_rst,
  input wire rd_req,
  input wire [1:0] rd_size,
  input wire wr_req,
  input wire [31:0] wr_data,
  input wire [3:0] lag,
  input wire fail_rd,
  input wire fail_wr,
  output reg rd_ack,
  output reg rd_err,
  output reg [31:0] rd_data,
  output reg wr_ack,
  output reg wr_err,
  output reg [31:0] wr_seen,
  output reg [7:0] nb,
  output reg [7:0] n_rd,
  output reg [7:0] n_wr
);
  reg [3:0] wait_q; // Cycles the open request has waited.
  wire busy = rd_ack || rd_err || wr_ack || wr_err;
  wire rd_go = rd_req && !busy && wait_q == lag;
  wire wr_go = wr_req && !busy && wait_q == lag;
  // Read data only holds during an answer; it toggles otherwise.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {rd_ack, rd_err, wr_ack, wr_err, wait_q, nb, n_rd, n_wr} <= 0;
      rd_data <= 32'h0000_0000;
      wr_seen <= 32'h0000_0000;
    end else begin
      rd_ack <= rd_go && !fail_rd;
      rd_err <= rd_go && fail_rd;
      wr_ack <= wr_go && !fail_wr;
      wr_err <= wr_go && fail_wr;
      wait_q <= (rd_go || wr_go || busy || !(rd_req || wr_req)) ? 4'h0 : wait_q + 4'h1;
      rd_data <= rd_go ? {nb + 8'h03, nb + 8'h02, nb + 8'h01, nb} : ~rd_data;
      if (rd_go && !fail_rd) begin
        nb <= nb + (8'h01 << rd_size);
        n_rd <= n_rd + 8'h01;
      end
      if (wr_go && !fail_wr) begin
        wr_seen <= wr_data;
        n_wr <= n_wr + 8'h01;
      end
    end
  end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "dma_cnt_defs.vh"
// Drives the register port and checks counts, flags and packed data.
module tb_top;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [1:0] avs_address = 2'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0000_0000;
  reg dreq_pin = 1'b0;
  reg [3:0] lag = 4'h0;
  reg fail_rd = 1'b0;
  reg fail_wr = 1'b0;
  wire [31:0] avs_readdata, rd_data, wr_data, wr_seen;
  wire avs_waitrequest, rd_req, single_cycle, rd_ack, rd_err, wr_req, wr_ack, wr_err, done_hs;
  wire [1:0] rd_size, wr_size;
  wire [7:0] nb, n_rd, n_wr;
  integer n_errors = 0;
  integer checks_done = 0;
  integer n_hs = 0;
  reg [31:0] got; // Last read data.
  always #2.5 core_clk = ~core_clk;
  // Counts done handshake pulses.
  always @(posedge core_clk) if (done_hs === 1'b1) n_hs <= n_hs + 1;
  dma_byte_count_and_packing DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rd_req(rd_req), .rd_size(rd_size),
    .single_cycle(single_cycle), .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data),
    .wr_req(wr_req), .wr_size(wr_size), .wr_data(wr_data), .wr_ack(wr_ack),
    .wr_err(wr_err), .dreq_pin(dreq_pin), .done_hs(done_hs));
  mem_partner mem (.core_clk(core_clk), .sys_rst(sys_rst), .rd_req(rd_req),
    .rd_size(rd_size), .wr_req(wr_req), .wr_data(wr_data), .lag(lag), .fail_rd(fail_rd),
    .fail_wr(fail_wr), .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data),
    .wr_ack(wr_ack), .wr_err(wr_err), .wr_seen(wr_seen), .nb(nb), .n_rd(n_rd), .n_wr(n_wr));
  task chk(input [95:0] nm, input [31:0] exp, input [31:0] seen);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      if (n_errors == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // One register access; the request holds until waitrequest is seen low.
  task bus(input wr, input [1:0] a, input [31:0] d);
    integer i;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      i = 0;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
        i = i + 1;
        if (i > 20) begin
          chk("bus timeout", 0, 1);
          close_out;
        end
        @(posedge core_clk);
      end
      got = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // Polls status until the summary bit shows.
  task wait_stat;
    integer i;
    begin
      i = 0;
      got = 0;
      while (got[7] !== 1'b1) begin
        i = i + 1;
        if (i > 200) begin
          chk("no finish", 1, 0);
          close_out;
        end
        bus(0, `REG_STAT_IDX, 0);
      end
    end
  endtask
  // A setup that must be refused without any source cycle.
  task bad(input [6:0] ctl, input [31:0] cnt);
    reg [7:0] r0;
    begin
      r0 = n_rd;
      bus(1, `REG_COUNT_IDX, cnt);
      bus(1, `REG_CTRL_IDX, {25'h0, ctl});
      wait_stat;
      chk("setup flag", 32'h0000_0088, got);
      chk("no read", 0, n_rd - r0);
      bus(1, `REG_STAT_IDX, 32'h0000_0008);
    end
  endtask
  // A full block; the last write must carry the last bytes read.
  task run(input [6:0] ctl, input [31:0] cnt, input [7:0] nr, input [7:0] nw,
           input [2:0] d, input [3:0] lg);
    reg [7:0] b0, r0, w0;
    integer k, h0;
    reg [31:0] e;
    begin
      b0 = nb;
      r0 = n_rd;
      w0 = n_wr;
      h0 = n_hs;
      lag <= lg;
      bus(1, `REG_COUNT_IDX, cnt);
      bus(1, `REG_CTRL_IDX, {25'h0, ctl});
      wait_stat;
      chk("status", 32'h0000_0081, got);
      bus(0, `REG_COUNT_IDX, 0);
      chk("count", 0, got);
      chk("reads", nr, n_rd - r0);
      chk("writes", nw, n_wr - w0);
      chk("handshake", ctl[6], n_hs - h0);
      e = 0;
      for (k = 0; k < d; k = k + 1) e[8*k +: 8] = b0 + cnt - d + k;
      if (d != 0) chk("last data", e, wr_seen & ~(32'hFFFF_FFFF << 8*d));
      bus(1, `REG_STAT_IDX, 32'h0000_0001);
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    bus(0, `REG_CTRL_IDX, 0);
    chk("ctrl reset", 0, got);
    bus(0, `REG_COUNT_IDX, 0);
    chk("count reset", `COUNT_RST, got);
    bus(1, 2'h3, 32'hFFFF_FFFF);
    bus(0, 2'h3, 0);
    chk("unmapped", 0, got);
    bad(7'h0B, 3);
    bad(7'h15, 6);
    bad(7'h15, 5);
    bad(7'h07, 8);
    bad(7'h01, 0);
    bus(0, `REG_CTRL_IDX, 0);
    chk("go dropped", 0, got);
    bus(1, `REG_CTRL_IDX, 32'h0000_0001);
    wait_stat;
    bus(1, `REG_COUNT_IDX, 32'h0000_0004);
    bus(1, `REG_STAT_IDX, 0);
    bus(1, `REG_CTRL_IDX, 32'h0000_0001);
    bus(0, `REG_CTRL_IDX, 0);
    chk("go refused", 0, got);
    bus(0, `REG_STAT_IDX, 0);
    chk("zero write", 32'h0000_0088, got);
    bus(1, `REG_STAT_IDX, 32'h0000_0008);
    bus(0, `REG_STAT_IDX, 0);
    chk("one write", 0, got);
    run(7'h01, 3, 3, 3, 1, 0);
    run(7'h0B, 4, 2, 2, 2, 3);
    run(7'h15, 8, 2, 2, 4, 1);
    run(7'h09, 8, 8, 4, 2, 2);
    run(7'h11, 8, 8, 2, 4, 0);
    run(7'h13, 8, 4, 2, 4, 5);
    run(7'h03, 8, 4, 8, 1, 0);
    run(7'h05, 8, 2, 8, 1, 2);
    run(7'h0D, 8, 2, 4, 2, 0);
    dreq_pin <= 1'b1;
    run(7'h4B, 4, 2, 2, 2, 1);
    dreq_pin <= 1'b0;
    run(7'h21, 2, 2, 0, 0, 0);
    fail_wr <= 1'b1;
    bus(1, `REG_COUNT_IDX, 32'h0000_0004);
    bus(1, `REG_CTRL_IDX, 32'h0000_000B);
    wait_stat;
    chk("dst error", 32'h0000_0084, got);
    bus(0, `REG_COUNT_IDX, 0);
    chk("count kept", 32'h0000_0004, got);
    bus(0, `REG_CTRL_IDX, 0);
    chk("go cleared", 32'h0000_000A, got);
    fail_wr <= 1'b0;
    fail_rd <= 1'b1;
    bus(1, `REG_STAT_IDX, 32'h0000_0004);
    bus(1, `REG_CTRL_IDX, 32'h0000_000B);
    wait_stat;
    chk("src error", 32'h0000_0082, got);
    bus(0, `REG_COUNT_IDX, 0);
    chk("next count", 32'h0000_0004, got);
    close_out;
  end
endmodule
bind dma_byte_count_and_packing dma_cnt_properties chk_i (.core_clk(core_clk),
  .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rd_req(rd_req),
  .rd_size(rd_size), .single_cycle(single_cycle), .rd_ack(rd_ack), .rd_err(rd_err),
  .rd_data(rd_data), .wr_req(wr_req), .wr_size(wr_size), .wr_data(wr_data),
  .wr_ack(wr_ack), .wr_err(wr_err), .dreq_pin(dreq_pin), .done_hs(done_hs));
